// ==== rtl/oefp_pkg.sv ====
// Purpose: Shared constants and types for the output and external-function port.
// Assumes: 25 MHz system clock, APB register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package oefp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_FUNC = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_LATCH = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_DESIG_POS = 4;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_ORES_POS = 1;
    localparam int STAT_FRES_POS = 2;
    localparam int STAT_REQ_POS = 3;
    localparam int STAT_FPEND_POS = 4;
    localparam int STAT_SLOT_POS = 8;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [4:0] SLOT_START = 5'h11;
    localparam logic [2:0] DESIG_WORD_A = 3'h0;
    localparam logic [2:0] DESIG_WORD_B = 3'h4;
    localparam int CHAR_BITS = 6;
    localparam int PUNCH_BITS = 7;
    localparam int WORD_BITS = 24;
    localparam int FUNC_BITS = 15;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_LOAD,
        ST_WAIT,
        ST_EMIT
    } oefp_state_e;

    // Peripheral-facing output group.
    typedef struct packed {
        logic [6:0] latch;
        logic outEnable;
        logic [14:0] funcLines;
        logic funcEnable;
    } oefp_periph_s;
endpackage
`default_nettype wire

// ==== rtl/oefp_port.sv ====
// Purpose: Output channel and external-function command port with APB registers.
// Assumes: Peripheral resume pulses are synchronous one-cycle strobes.
// Notes: Word output sends four six-bit characters, most significant first.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`default_nettype none
module oefp_port #(
    parameter int WORD_W = 24,
    parameter int FUNC_W = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic outResume,
    input wire logic funcResume,
    output oefp_pkg::oefp_periph_s periph
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wrAcc;
    logic rdAcc;
    logic mapped;
    logic [2:0] desig_ff;
    logic [WORD_W-1:0] operand_ff;
    logic [FUNC_W-1:0] pointer_ff;
    logic outReq_ff;
    logic outRes_ff;
    logic funcPend_ff;
    logic funcRes_ff;
    logic [6:0] xfer_ff;
    logic [WORD_W-1:0] shift_ff;
    logic [4:0] slot_ff;
    logic wordMode_ff;
    logic [6:0] latch_ff;
    logic outEn_ff;
    logic [FUNC_W-1:0] cmd_ff;
    logic funcEn_ff;
    oefp_pkg::oefp_state_e state_ff;
    logic startOut;
    logic startFunc;
    logic transferNow;
    logic busy;
    logic [2:0] newDesig;

    // Slot tracker shifts its low four stages left with an end-around path from stage 3; the top stage holds.
    // Four steps bring the tracker back to its start, which ends a word.
    function automatic logic [4:0] slotStep(input logic [4:0] s);
        slotStep = {s[4], s[2:0], s[3]};
    endfunction

    // The bus answers in the access cycle; no wait states are inserted.
    // Read data is captured in the setup cycle, so it reflects state one cycle early.
    assign pready = 1'b1;
    assign mapped = (paddr == oefp_pkg::OFS_CTRL) || (paddr == oefp_pkg::OFS_OPERAND)
        || (paddr == oefp_pkg::OFS_FUNC) || (paddr == oefp_pkg::OFS_STATUS)
        || (paddr == oefp_pkg::OFS_LATCH);
    assign pslverr = psel && penable && !mapped;
    assign wrAcc = psel && penable && pwrite && mapped && clkEn;
    assign rdAcc = psel && !penable && !pwrite;
    assign busy = (state_ff != oefp_pkg::ST_IDLE);
    // The designator travels with the start write itself; using the register
    // copy would start with the previous command's designator.
    assign newDesig = pwdata[oefp_pkg::CTRL_DESIG_POS +: 3];
    // A new command is ignored while the previous output is still moving.
    assign startOut = wrAcc && (paddr == oefp_pkg::OFS_CTRL)
        && pwdata[oefp_pkg::CTRL_START_POS] && !busy;
    assign startFunc = wrAcc && (paddr == oefp_pkg::OFS_FUNC) && !funcPend_ff;

    // Writable registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            desig_ff <= 3'h0;
            operand_ff <= '0;
        end else if (wrAcc) begin
            if (paddr == oefp_pkg::OFS_CTRL && !busy)
                desig_ff <= newDesig;
            if (paddr == oefp_pkg::OFS_OPERAND)
                operand_ff <= pwdata[WORD_W-1:0];
        end
    end

    // Read data is registered during the setup cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= oefp_pkg::RD_UNMAPPED;
        end else if (clkEn && rdAcc) begin
            prdata <= oefp_pkg::RD_UNMAPPED;
            unique case (paddr)
                oefp_pkg::OFS_CTRL: prdata <= {25'h0, desig_ff, 4'h0};
                oefp_pkg::OFS_OPERAND: prdata <= {{(32-WORD_W){1'b0}}, operand_ff};
                oefp_pkg::OFS_FUNC: prdata <= {{(32-FUNC_W){1'b0}}, cmd_ff};
                oefp_pkg::OFS_STATUS: prdata <= {19'h0, slot_ff, 3'h0, funcPend_ff,
                    outReq_ff, funcRes_ff, outRes_ff, busy};
                oefp_pkg::OFS_LATCH: prdata <= {25'h0, latch_ff};
                default: prdata <= oefp_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output sequencer
    // ------------------------------------------------------------
    // transfer gate
    assign transferNow = outReq_ff && outRes_ff;

    // Sequencer steps: copy and shift, load the transfer register, wait for the
    // resume flag, then step the slot tracker or finish.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= oefp_pkg::ST_IDLE;
            outReq_ff <= 1'b0;
            xfer_ff <= 7'h00;
            shift_ff <= '0;
            slot_ff <= 5'h00;
            wordMode_ff <= 1'b0;
        end else if (clkEn) begin
            unique case (state_ff)
                oefp_pkg::ST_IDLE: begin
                    if (startOut) begin
                        if (newDesig == oefp_pkg::DESIG_WORD_A
                            || newDesig == oefp_pkg::DESIG_WORD_B) begin
                            // load shifter, slot start and step
                            shift_ff <= operand_ff;
                            slot_ff <= slotStep(oefp_pkg::SLOT_START);
                            wordMode_ff <= 1'b1;
                            state_ff <= oefp_pkg::ST_SHIFT;
                        end else begin
                            xfer_ff <= operand_ff[6:0];
                            outReq_ff <= 1'b1;
                            wordMode_ff <= 1'b0;
                            state_ff <= oefp_pkg::ST_WAIT;
                        end
                    end
                end
                oefp_pkg::ST_SHIFT: begin
                    shift_ff <= {shift_ff[WORD_W-oefp_pkg::CHAR_BITS-1:0],
                        shift_ff[WORD_W-1 -: oefp_pkg::CHAR_BITS]};
                    state_ff <= oefp_pkg::ST_LOAD;
                end
                oefp_pkg::ST_LOAD: begin
                    // only six bits reach transfer register
                    xfer_ff <= {1'b0, shift_ff[oefp_pkg::CHAR_BITS-1:0]};
                    outReq_ff <= 1'b1;
                    state_ff <= oefp_pkg::ST_WAIT;
                end
                oefp_pkg::ST_WAIT: begin
                    // A preset flag lets the first character after a clear leave at once.
                    // hold until resume
                    if (transferNow) begin
                        outReq_ff <= 1'b0;
                        state_ff <= oefp_pkg::ST_EMIT;
                    end
                end
                oefp_pkg::ST_EMIT: begin
                    // finish when tracker back at start
                    if (!wordMode_ff || slot_ff == oefp_pkg::SLOT_START) begin
                        state_ff <= oefp_pkg::ST_IDLE;
                    end else begin
                        slot_ff <= slotStep(slot_ff);
                        state_ff <= oefp_pkg::ST_SHIFT;
                    end
                end
                // Unused state codes fall back to idle rather than hang the port.
                default: begin
                    state_ff <= oefp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Output resume flag; a pulse arriving with the clear wins.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            outRes_ff <= 1'b1;
        end else if (clkEn) begin
            if (outResume)
                outRes_ff <= 1'b1;
            else if (transferNow)
                outRes_ff <= 1'b0;
        end
    end

    // Output latch and its one-cycle enable.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_ff <= 7'h00;
            outEn_ff <= 1'b0;
        end else if (clkEn) begin
            outEn_ff <= 1'b0;
            if (transferNow) begin
                // clear then load low seven bits
                latch_ff <= xfer_ff;
                outEn_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // External function path
    // ------------------------------------------------------------
    // Pointer capture. A command written while one is pending is dropped,
    // so software must poll the pending flag before writing again.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pointer_ff <= '0;
            funcPend_ff <= 1'b0;
        end else if (clkEn) begin
            if (startFunc) begin
                pointer_ff <= pwdata[FUNC_W-1:0];
                funcPend_ff <= 1'b1;
            end else if (funcPend_ff && funcRes_ff) begin
                funcPend_ff <= 1'b0;
            end
        end
    end

    // Function resume flag; a pulse arriving with the clear wins.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            funcRes_ff <= 1'b1;
        end else if (clkEn) begin
            if (funcResume)
                funcRes_ff <= 1'b1;
            else if (funcPend_ff && funcRes_ff)
                funcRes_ff <= 1'b0;
        end
    end

    // Command latch is overwritten whole, which also clears stale bits.
    // Lines and enable register at one edge, so the code is settled before any
    // peripheral samples it on the enable.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_ff <= '0;
            funcEn_ff <= 1'b0;
        end else if (clkEn) begin
            funcEn_ff <= 1'b0;
            if (funcPend_ff && funcRes_ff) begin
                cmd_ff <= pointer_ff;
                funcEn_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral outputs
    // ------------------------------------------------------------
    // continuous presentation
    // digits in octal order, top first
    always_comb begin
        periph.latch = latch_ff;
        periph.outEnable = outEn_ff;
        periph.funcLines = cmd_ff;
        periph.funcEnable = funcEn_ff;
    end
endmodule
`default_nettype wire

// ==== test/oefp_properties.sv ====
// Purpose: Pin-level timing checks for oefp_port.
// Assumes: Outputs are started only while the block is idle.
// Notes: Attached to every port instance by bind.
`default_nettype none
module oefp_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic outResume,
    input wire logic funcResume,
    input wire oefp_pkg::oefp_periph_s periph
);
    logic oGot_ff;
    logic fGot_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // --------
    // Helpers
    // --------
    // flags preset
    // Mirrors both resume flags; a pulse beats the clear, as the block does.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oGot_ff <= 1'b1;
            fGot_ff <= 1'b1;
        end else begin
            oGot_ff <= outResume | (oGot_ff & ~periph.outEnable);
            fGot_ff <= funcResume | (fGot_ff & ~periph.funcEnable);
        end
    end
    sequence s_start;
        psel && penable && pwrite && paddr == oefp_pkg::OFS_CTRL && pwdata[0];
    endsequence
    sequence s_func;
        psel && penable && pwrite && paddr == oefp_pkg::OFS_FUNC;
    endsequence
    // --------
    // Properties
    // --------
    property p_outSoon;
        s_start |-> ##[1:40] periph.outEnable;
    endproperty
    property p_latchEn;
        !$stable(periph.latch) |-> periph.outEnable || periph.latch == 7'h00;
    endproperty
    property p_outPulse;
        periph.outEnable |=> !periph.outEnable;
    endproperty
    property p_outGated;
        periph.outEnable |-> oGot_ff;
    endproperty
    property p_funcSoon;
        s_func |-> ##[1:40] periph.funcEnable;
    endproperty
    property p_funcEn;
        !$stable(periph.funcLines) |-> periph.funcEnable || periph.funcLines == 15'h0000;
    endproperty
    property p_funcPulse;
        periph.funcEnable |=> !periph.funcEnable;
    endproperty
    property p_funcGated;
        periph.funcEnable |-> fGot_ff;
    endproperty
    a_outSoon: assert property (p_outSoon)
        else $error("output start gave no enable");
    a_latchEn: assert property (p_latchEn)
        else $error("latch moved without enable");
    a_outPulse: assert property (p_outPulse)
        else $error("output enable too long");
    a_outGated: assert property (p_outGated)
        else $error("character sent without resume");
    a_funcSoon: assert property (p_funcSoon)
        else $error("command gave no enable");
    a_funcEn: assert property (p_funcEn)
        else $error("command lines moved without enable");
    a_funcPulse: assert property (p_funcPulse)
        else $error("function enable too long");
    a_funcGated: assert property (p_funcGated)
        else $error("command sent without resume");
endmodule
bind oefp_port oefp_properties u_oefp_properties (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .outResume, .funcResume, .periph);
`default_nettype wire

// ==== test/oefp_periph_model.sv ====
// Purpose: Behavioural peripheral that records characters and answers enables.
// Assumes: Resume answers are one clock wide.
// Notes: Hold stalls both answers to model a slow unit.
`default_nettype none
module oefp_periph_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic hold,
    input wire logic punchSel,
    input wire oefp_pkg::oefp_periph_s periph,
    output logic outResume,
    output logic funcResume,
    output logic [6:0] gotChar,
    output logic fault,
    output logic [2:0] ctlUnit
);
    logic oPend_ff;
    logic fPend_ff;
    // sample, then answer
    // Lines are read only on an enable; the answer waits while hold is high.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oPend_ff <= 1'b0;
            fPend_ff <= 1'b0;
            outResume <= 1'b0;
            funcResume <= 1'b0;
            gotChar <= 7'h00;
        end else begin
            oPend_ff <= periph.outEnable | (oPend_ff & hold);
            fPend_ff <= periph.funcEnable | (fPend_ff & hold);
            outResume <= oPend_ff & ~hold;
            funcResume <= fPend_ff & ~hold;
            if (periph.outEnable) begin
                gotChar <= punchSel ? periph.latch : {1'b0, periph.latch[5:0]};
            end
        end
    end
    // lower digits left to the named unit
    // Every unit watches the class digit and keeps the control digit that
    // names the interpreter; the four unused classes raise the fault line.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault <= 1'b0;
            ctlUnit <= 3'h0;
        end else if (periph.funcEnable) begin
            fault <= (periph.funcLines[14:12] == 3'h3) || (periph.funcLines[14:12] >= 3'h5);
            ctlUnit <= periph.funcLines[11:9];
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_oefp_port.sv ====
// Purpose: Self-checking bench for oefp_port.
// Assumes: Run enable tied high; the peripheral model answers each enable.
// Notes: Each scenario task judges its own results.
`default_nettype none
module tb_oefp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, psel, penable, pwrite, hold, punchSel, pready, pslverr, err, seen;
    logic outResume, funcResume;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, op;
    logic [14:0] code [4] = '{15'o04010, 15'o24221, 15'o41203, 15'o74567};
    logic [6:0] gotChar;
    logic fault;
    logic [2:0] ctlUnit;
    oefp_pkg::oefp_periph_s periph;
    int n_fail = 0;
    int checks_done = 0;
    oefp_port u_oefp_port (.clk, .reset, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .outResume, .funcResume, .periph);
    oefp_periph_model u_oefp_periph_model (.clk, .reset, .hold, .punchSel, .periph,
        .outResume, .funcResume, .gotChar, .fault, .ctlUnit);
    // --------
    // Shared tasks
    // --------
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Starts on an edge, so a transfer never follows the last release in one step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Samples at the falling edge, where registered outputs have settled.
    task automatic wait_en(input logic func, input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clk);
            seen = func ? periph.funcEnable : periph.outEnable;
        end
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_reset;
        apb(1'b0, oefp_pkg::OFS_STATUS, 32'h0);
        check(rd & 32'h1F, 32'h6);
        check(32'(periph.latch), 32'h0);
        check(32'(periph.funcLines), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_single;
        for (int d = 1; d < 8; d++) begin
            op = 32'h00AB_CD80 + 32'(d * 9);
            punchSel <= d[0];
            apb(1'b1, oefp_pkg::OFS_OPERAND, op);
            apb(1'b1, oefp_pkg::OFS_CTRL, 32'(d << 4) | 32'h1);
            wait_en(1'b0, 40);
            check(32'(periph.latch), op & 32'h7F);
            @(negedge clk);
            check(32'(gotChar), op & (d[0] ? 32'h7F : 32'h3F));
            if (d == 3) d++;
        end
        $display("test single done");
    endtask
    task automatic t_resume;
        repeat (3) @(negedge clk);
        hold <= 1'b1;
        apb(1'b1, oefp_pkg::OFS_CTRL, 32'h11);
        wait_en(1'b0, 40);
        apb(1'b1, oefp_pkg::OFS_OPERAND, 32'h2A);
        apb(1'b1, oefp_pkg::OFS_CTRL, 32'h11);
        wait_en(1'b0, 15);
        check(32'(seen), 32'h0);
        hold <= 1'b0;
        wait_en(1'b0, 40);
        check(32'(periph.latch), 32'h2A);
        $display("test resume done");
    endtask
    task automatic t_word;
        for (int m = 0; m < 8; m += 4) begin
            op = m == 0 ? 32'h00B2_C3D4 : 32'h00FF_F03F;
            apb(1'b1, oefp_pkg::OFS_OPERAND, op);
            apb(1'b1, oefp_pkg::OFS_CTRL, 32'(m << 4) | 32'h1);
            for (int k = 0; k < 4; k++) begin
                wait_en(1'b0, 40);
                check(32'(periph.latch), (op >> (18 - 6 * k)) & 32'h3F);
            end
            wait_en(1'b0, 20);
            check(32'(seen), 32'h0);
        end
        $display("test word done");
    endtask
    task automatic t_func;
        foreach (code[i]) begin
            apb(1'b1, oefp_pkg::OFS_FUNC, 32'(code[i]));
            wait_en(1'b1, 40);
            check(32'(periph.funcLines), 32'(code[i]));
            @(negedge clk);
            check(32'(fault), 32'(i == 3));
            check(32'(ctlUnit), 32'(code[i][11:9]));
        end
        // Withhold the answer to the last code, so the next command must wait.
        hold <= 1'b1;
        apb(1'b1, oefp_pkg::OFS_FUNC, 32'h1357);
        wait_en(1'b1, 15);
        check(32'(seen), 32'h0);
        check(32'(periph.funcLines), 32'(code[3]));
        hold <= 1'b0;
        wait_en(1'b1, 40);
        check(32'(periph.funcLines), 32'h1357);
        $display("test func done");
    endtask
    // Clear in mid-run with both answers withheld: the flags must come back preset.
    task automatic t_clear;
        repeat (4) @(negedge clk);
        hold <= 1'b1;
        apb(1'b1, oefp_pkg::OFS_CTRL, 32'h11);
        wait_en(1'b0, 40);
        apb(1'b1, oefp_pkg::OFS_FUNC, 32'h0123);
        wait_en(1'b1, 40);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        apb(1'b1, oefp_pkg::OFS_CTRL, 32'h11);
        wait_en(1'b0, 40);
        check(32'(seen), 32'h1);
        apb(1'b1, oefp_pkg::OFS_FUNC, 32'h0321);
        wait_en(1'b1, 40);
        check(32'(seen), 32'h1);
        check(32'(periph.funcLines), 32'h0321);
        hold <= 1'b0;
        $display("test clear done");
    endtask
    // Main sequence.
    initial begin
        {psel, penable, pwrite, hold, punchSel} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_resume();
        t_word();
        t_func();
        t_clear();
        finish_test();
    end
    // Cuts a hang short well past the few hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
